// >>> common/pirf_pkg.sv
/*
  Package for the peripheral interrupt flag register block: register offsets,
  flag bit positions, reset values and the event-bundle struct.
  Assumes a single core clock and a synchronous active-low reset.
*/
package pirf_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] PIRF_FLAGS_OFFSET = 8'h0C;
  localparam logic [7:0] PIRF_MASK_OFFSET = 8'h8C;
  localparam logic [7:0] PIRF_POST_OFFSET = 8'h12;

  // ==========================================================================
  // Flag bit positions
  localparam int PIRF_BIT_HOST = 7;
  localparam int PIRF_BIT_CONV = 6;
  localparam int PIRF_BIT_RX = 5;
  localparam int PIRF_BIT_TX = 4;
  localparam int PIRF_BIT_RSVD = 3;
  localparam int PIRF_BIT_CC = 2;
  localparam int PIRF_BIT_PERIOD = 1;
  localparam int PIRF_BIT_WIDE = 0;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] PIRF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] PIRF_MASK_RESET = 8'h00;
  localparam logic [3:0] PIRF_POST_RESET = 4'h0;
  localparam logic [7:0] PIRF_STICKY_MASK = 8'hC7;
  localparam logic [7:0] PIRF_FLAG_WMASK = 8'hC7;
  localparam logic [7:0] PIRF_MASK_WMASK = 8'hF7;

  // ==========================================================================
  // Capture/compare unit modes
  typedef enum logic [1:0] {
    PIRF_CC_OFF = 2'h0,
    PIRF_CC_CAPTURE = 2'h1,
    PIRF_CC_COMPARE = 2'h3,
    PIRF_CC_PWM = 2'h2
  } pirf_cc_mode_t;

  // Peripheral event bundle, all one-cycle pulses except buffer levels
  typedef struct packed {
    logic host_access;
    logic conv_done;
    logic rx_full;
    logic tx_empty;
    logic cc_capture;
    logic cc_match;
    logic period_match;
    logic wide_overflow;
  } pirf_events_t;

endpackage

// >>> rtl/pirf_flag_reg.sv
/*
  Peripheral interrupt flag register with mask and one level interrupt.
  Register map on the strobe port:
    PIRF_FLAGS_OFFSET - sticky event flags 7, 6, 2, 1, 0; buffer mirrors 5, 4; bit 3 reads zero
    PIRF_MASK_OFFSET - same layout, gates each flag onto o_irq
    PIRF_POST_OFFSET - bits 3:0 choose the period-match postscaler ratio, value plus one
  Assumes event sources run on i_clk (no synchronisers) and the core reaches
  the registers over a plain strobe port with read data one cycle later.
  Assumes each event input is high for one cycle per event, except the two buffer levels.
*/
// Function
// - Flags set on their event regardless of any enable bit.
// - Eight-bit flag register at 0x0C; bit 3 always reads zero.
// - Host port access sets bit 7; it stays until software clears it.
// - Conversion done sets bit 6; bit is readable and writable.
// - Bit 5 read-only, mirrors receive buffer holding data.
// - Bit 4 read-only, mirrors transmit buffer empty.
// - Capture mode: timer capture sets bit 2 until software clears it.
// - Compare mode: match sets bit 2; pulse-width mode never sets it.
// - Period timer match sets bit 1 until software clears it.
// - Wide timer overflow sets bit 0 until software clears it.
// - Period matches pass a 4-bit postscaler, ratio one to sixteen.
module pirf_flag_reg
  import pirf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Peripheral events
  input wire pirf_events_t i_events,
  input wire pirf_cc_mode_t i_cc_mode,
  // Interrupt
  output logic o_irq
);

  // ==========================================================================
  // Register state and next values
  logic [7:0] flags_reg, flags_next;
  logic [7:0] mask_reg, mask_next;
  logic [3:0] post_ratio_reg, post_ratio_next;
  logic [3:0] post_cnt_reg, post_cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  // Combinational helpers
  logic [7:0] set_vec; // Hardware set requests, one per flag bit
  logic [7:0] flags_view; // Flags as software reads them
  logic post_fire; // One-cycle postscaler output
  logic wr_flags, wr_mask, wr_post;

  // ==========================================================================
  // Write decode; the three strobes never come together, so no priority is needed
  assign wr_flags = i_wr && (i_addr == PIRF_FLAGS_OFFSET);
  assign wr_mask = i_wr && (i_addr == PIRF_MASK_OFFSET);
  assign wr_post = i_wr && (i_addr == PIRF_POST_OFFSET);

  // ==========================================================================
  // Postscaler: counts period matches, fires on the selected count
  // Ratio is value plus one, so 4'h0 passes every match and 4'hF one in sixteen
  // The count restarts on a ratio write; a smaller ratio can never strand it above
  always_comb begin
    post_cnt_next = post_cnt_reg;
    post_fire = 1'b0;
    if (wr_post) begin
      post_cnt_next = 4'h0; // New ratio restarts the count cleanly
    end else if (i_events.period_match) begin
      if (post_cnt_reg == post_ratio_reg) begin
        post_fire = 1'b1;
        post_cnt_next = 4'h0;
      end else begin
        post_cnt_next = post_cnt_reg + 4'h1;
      end
    end
    post_ratio_next = wr_post ? i_wdata[3:0] : post_ratio_reg;
  end

  // ==========================================================================
  // Sticky set sources, gated only by mode, never by mask
  // Capture and match pulses only count in their own mode; pulse-width mode drops both
  always_comb begin
    set_vec = 8'h00;
    set_vec[PIRF_BIT_HOST] = i_events.host_access;
    set_vec[PIRF_BIT_CONV] = i_events.conv_done;
    set_vec[PIRF_BIT_CC] = (i_cc_mode == PIRF_CC_CAPTURE && i_events.cc_capture)
      || (i_cc_mode == PIRF_CC_COMPARE && i_events.cc_match);
    set_vec[PIRF_BIT_PERIOD] = post_fire;
    set_vec[PIRF_BIT_WIDE] = i_events.wide_overflow;
  end

  // Flag and mask updates; software writes the stored value, set wins
  // Bits 5, 4 and 3 are never stored; the read view fills them in
  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = (flags_reg & ~PIRF_FLAG_WMASK) | (i_wdata & PIRF_FLAG_WMASK);
    end
    flags_next = (flags_next | set_vec) & PIRF_STICKY_MASK;
    mask_next = wr_mask ? (i_wdata & PIRF_MASK_WMASK) : mask_reg;
  end

  // Live view: buffer mirrors fill bits 5 and 4, bit 3 forced low
  // Mirrors are combinational so software sees the buffer state of this very cycle
  always_comb begin
    flags_view = flags_reg;
    flags_view[PIRF_BIT_RX] = i_events.rx_full;
    flags_view[PIRF_BIT_TX] = i_events.tx_empty;
    flags_view[PIRF_BIT_RSVD] = 1'b0;
  end

  // Read mux; unmapped addresses answer zero
  // Strobe-gated so the read data are zero outside the answer cycle
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        PIRF_FLAGS_OFFSET: rdata_next = flags_view;
        PIRF_MASK_OFFSET: rdata_next = mask_reg;
        PIRF_POST_OFFSET: rdata_next = {4'h0, post_ratio_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Registers, one bank per group of state
  // Postscaler ratio and count; both restart on reset so the first match is 1:1
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      post_ratio_reg <= PIRF_POST_RESET;
      post_cnt_reg <= PIRF_POST_RESET;
    end else begin
      post_ratio_reg <= post_ratio_next;
      post_cnt_reg <= post_cnt_next;
    end
  end

  // Stored flags and interrupt mask
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      flags_reg <= PIRF_FLAGS_RESET;
      mask_reg <= PIRF_MASK_RESET;
    end else begin
      flags_reg <= flags_next;
      mask_reg <= mask_next;
    end
  end

  // Read data; returns to zero after one cycle so a stale word never lingers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Level interrupt, includes mirrored buffer bits; a flag left pending when
  // software enables its mask bit raises the line at once
  assign o_irq = |(flags_view & mask_reg);
  assign o_rdata = rdata_reg;

  // ==========================================================================
  // Assertions
  a_event_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_events.wide_overflow |=> flags_reg[PIRF_BIT_WIDE])
    else $error("Overflow event did not set flag");
  a_host_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    flags_reg[PIRF_BIT_HOST] && !wr_flags |=> flags_reg[PIRF_BIT_HOST])
    else $error("Host access flag dropped without a write");
  a_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rd && i_addr == PIRF_FLAGS_OFFSET |=> !o_rdata[PIRF_BIT_RSVD])
    else $error("Reserved bit read as one");
  a_conv_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_flags && !i_events.conv_done |=> flags_reg[PIRF_BIT_CONV] == $past(i_wdata[PIRF_BIT_CONV]))
    else $error("Conversion flag not writable");
  a_rx_mirror: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rd && i_addr == PIRF_FLAGS_OFFSET |=> o_rdata[PIRF_BIT_RX] == $past(i_events.rx_full))
    else $error("Receive mirror wrong");
  a_tx_mirror: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rd && i_addr == PIRF_FLAGS_OFFSET |=> o_rdata[PIRF_BIT_TX] == $past(i_events.tx_empty))
    else $error("Transmit mirror wrong");
  a_capture_sets: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cc_mode == PIRF_CC_CAPTURE && i_events.cc_capture |=> flags_reg[PIRF_BIT_CC])
    else $error("Capture did not set flag");
  a_pwm_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cc_mode == PIRF_CC_PWM && !flags_reg[PIRF_BIT_CC] && !wr_flags |=> !flags_reg[PIRF_BIT_CC])
    else $error("Pulse-width mode set the flag");
  a_post_ratio: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    post_fire |-> post_cnt_reg == post_ratio_reg && i_events.period_match)
    else $error("Postscaler fired off count");
  a_period_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    post_fire |=> flags_reg[PIRF_BIT_PERIOD])
    else $error("Period flag not set");
  a_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_flags && !i_wdata[PIRF_BIT_WIDE] && i_events.wide_overflow |=> flags_reg[PIRF_BIT_WIDE])
    else $error("Clear beat a hardware set");
  a_overflow_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    flags_reg[PIRF_BIT_WIDE] && !wr_flags |=> flags_reg[PIRF_BIT_WIDE])
    else $error("Overflow flag dropped");

  // ==========================================================================
  // Assertions: per-bit storage
  // Each stored bit holds and takes its set; unstored bits never hold a one
  for (genvar b = 0; b < 8; b++) begin : g_flag_chk
    if (PIRF_STICKY_MASK[b]) begin : g_sticky
      a_flag_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        flags_reg[b] && !wr_flags |=> flags_reg[b])
        else $error("Stored flag dropped without a write");
      a_set_lands: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        set_vec[b] |=> flags_reg[b])
        else $error("Hardware set did not land");
    end else begin : g_unstored
      a_stored_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !flags_reg[b])
        else $error("Unstored flag bit holds a one");
    end
  end

  // ==========================================================================
  // Assertions: event sources
  a_host_sets: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_events.host_access |=> flags_reg[PIRF_BIT_HOST])
    else $error("Host access did not set flag");
  a_conv_sets: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_events.conv_done |=> flags_reg[PIRF_BIT_CONV])
    else $error("Conversion done did not set flag");
  a_compare_sets: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cc_mode == PIRF_CC_COMPARE && i_events.cc_match |=> flags_reg[PIRF_BIT_CC])
    else $error("Compare match did not set flag");
  // Capture mode must ignore a match pulse, or a stray compare would look like a capture
  a_capture_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cc_mode == PIRF_CC_CAPTURE && !i_events.cc_capture && !flags_reg[PIRF_BIT_CC] && !wr_flags
    |=> !flags_reg[PIRF_BIT_CC])
    else $error("Capture flag set without a capture");

  // ==========================================================================
  // Assertions: register port
  a_flag_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_flags && set_vec == 8'h00 |=> flags_reg == ($past(i_wdata) & PIRF_STICKY_MASK))
    else $error("Flag write not stored");
  a_mask_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_mask |=> mask_reg == ($past(i_wdata) & PIRF_MASK_WMASK))
    else $error("Mask write not stored");
  a_mask_rsvd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !mask_reg[PIRF_BIT_RSVD])
    else $error("Mask bit 3 holds a one");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_rd |=> o_rdata == 8'h00)
    else $error("Read data outside answer cycle");
  a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_rd && i_addr != PIRF_FLAGS_OFFSET && i_addr != PIRF_MASK_OFFSET && i_addr != PIRF_POST_OFFSET
    |=> o_rdata == 8'h00)
    else $error("Unmapped read returned data");
  // Reset check runs without the disable so it can see the reset cycle itself
  a_reset_clear: assert property (@(posedge i_clk)
    !i_rst_b |=> flags_reg == PIRF_FLAGS_RESET && mask_reg == PIRF_MASK_RESET && o_rdata == 8'h00)
    else $error("Reset left state behind");

  // ==========================================================================
  // Assertions: postscaler
  a_post_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    post_cnt_reg <= post_ratio_reg)
    else $error("Postscaler count passed its ratio");
  a_post_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_post |=> post_cnt_reg == 4'h0 && post_ratio_reg == $past(i_wdata[3:0]))
    else $error("Ratio write did not restart count");
  a_post_fires: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_events.period_match && !wr_post && post_cnt_reg == post_ratio_reg |-> post_fire)
    else $error("Postscaler missed its count");
  a_post_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_events.period_match |-> !post_fire)
    else $error("Postscaler fired without a match");

  // ==========================================================================
  // Assertions: interrupt line
  a_irq_wide: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    flags_reg[PIRF_BIT_WIDE] && mask_reg[PIRF_BIT_WIDE] |-> o_irq)
    else $error("Enabled overflow flag gave no interrupt");
  a_irq_rx: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_events.rx_full && mask_reg[PIRF_BIT_RX] |-> o_irq)
    else $error("Enabled receive level gave no interrupt");
  a_irq_tx: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_events.tx_empty && mask_reg[PIRF_BIT_TX] |-> o_irq)
    else $error("Enabled transmit level gave no interrupt");
  a_irq_masked: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    mask_reg == 8'h00 |-> !o_irq)
    else $error("Interrupt with every enable clear");

  // Main scenarios worth seeing at least once
  c_irq_raise: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_irq));
  c_post_fire: cover property (@(posedge i_clk) disable iff (!i_rst_b) post_fire && post_ratio_reg == 4'hF);
  c_set_clear: cover property (@(posedge i_clk) disable iff (!i_rst_b) wr_flags && |set_vec);
  c_compare: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cc_mode == PIRF_CC_COMPARE && i_events.cc_match);
  c_capture_set: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cc_mode == PIRF_CC_CAPTURE && i_events.cc_capture);

endmodule

// >>> test/pirf_event_src.sv
/*
  Model of the peripheral event sources that feed the flag register.
  Assumes the bench raises i_fire bits for one cycle per event.
*/
module pirf_event_src
  import pirf_pkg::*;
(
  // Commands from the bench
  input wire logic [7:0] i_fire,
  input wire logic i_rx,
  input wire logic i_tx,
  // Events toward the block
  output pirf_events_t o_events
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Pulses pass as given; the serial buffer bits are levels instead
  always_comb begin
    o_events = i_fire;
    o_events.rx_full = i_rx;
    o_events.tx_empty = i_tx;
  end
endmodule

// >>> test/pirf_flag_reg_bench.sv
/*
  Self-checking bench for the flag register, driving events through a source model.
  Assumes one 125 MHz clock and a synchronous active-low reset.
*/
module pirf_flag_reg_bench
  import pirf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic rx = 1'b0;
  logic tx = 1'b1;
  logic o_irq;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] fire = 8'h00;
  logic [7:0] o_rdata;
  pirf_events_t ev;
  pirf_cc_mode_t mode = PIRF_CC_OFF;
  logic [7:0] expq[$];
  int errors = 0;
  int n_tests = 0;
  int r;
  // Event pulse, capture/compare mode and expected flag per row; last four must not set anything
  logic [7:0] ft[10] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01, 8'h0C, 8'h04, 8'h08, 8'h0C};
  logic [7:0] fx[10] = '{8'h80, 8'h40, 8'h04, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  pirf_cc_mode_t md[10] = '{PIRF_CC_OFF, PIRF_CC_OFF, PIRF_CC_CAPTURE, PIRF_CC_COMPARE, PIRF_CC_OFF,
    PIRF_CC_OFF, PIRF_CC_PWM, PIRF_CC_CAPTURE, PIRF_CC_COMPARE, PIRF_CC_OFF};
  pirf_flag_reg u_pirf_flag_reg(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_events(ev), .i_cc_mode(mode), .o_irq(o_irq));
  pirf_event_src u_pirf_event_src(.i_fire(fire), .i_rx(rx), .i_tx(tx), .o_events(ev));
  // ====================
  // Clock, checking and bus tasks
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Expected flag word: mirror bits follow the buffer levels held at read time
  function automatic logic [7:0] fl(input logic [7:0] s);
    return s | {2'b00, rx, tx, 4'h0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    expq.push_back(exp);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge i_clk);
    fire <= m;
    @(posedge i_clk);
    fire <= 8'h00;
  endtask
  // Read data stand only in the cycle after the strobe, so compare exactly there
  always @(posedge i_clk) begin
    if (rd_seen) check(o_rdata, expq.pop_front());
    rd_seen <= i_rd;
  end
  // Hang guard; the full run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    give_verdict();
  end
  // ====================
  // Test sequence
  initial begin
    void'($urandom(32'h97f9));
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(PIRF_FLAGS_OFFSET, 8'h10);
    rd(PIRF_MASK_OFFSET, 8'h00);
    rd(PIRF_POST_OFFSET, 8'h00);
    rd(8'h55, 8'h00);
    $display("test reset done");
    foreach (ft[i]) begin
      mode <= md[i];
      rx <= 1'($urandom);
      tx <= 1'($urandom);
      pulse(ft[i]);
      rd(PIRF_FLAGS_OFFSET, fl(fx[i]));
      wr(PIRF_FLAGS_OFFSET, 8'h00);
      rd(PIRF_FLAGS_OFFSET, fl(8'h00));
    end
    $display("test event flags done");
    for (int k = 0; k < 2; k++) begin
      r = k ? 15 : $urandom_range(14);
      wr(PIRF_POST_OFFSET, 8'(r));
      rd(PIRF_POST_OFFSET, 8'(r));
      repeat (r) pulse(8'h02);
      rd(PIRF_FLAGS_OFFSET, fl(8'h00));
      pulse(8'h02);
      rd(PIRF_FLAGS_OFFSET, fl(8'h02));
      wr(PIRF_FLAGS_OFFSET, 8'h00);
    end
    $display("test postscaler done");
    wr(PIRF_FLAGS_OFFSET, 8'hFF);
    rd(PIRF_FLAGS_OFFSET, fl(8'hC7));
    fork
      wr(PIRF_FLAGS_OFFSET, 8'h00);
      pulse(8'h01);
    join
    rd(PIRF_FLAGS_OFFSET, fl(8'h01));
    $display("test write and collision done");
    wr(PIRF_FLAGS_OFFSET, 8'h00);
    wr(PIRF_MASK_OFFSET, 8'hFF);
    rd(PIRF_MASK_OFFSET, 8'hF7);
    wr(PIRF_MASK_OFFSET, 8'h01);
    #1 check({7'h00, o_irq}, 8'h00);
    pulse(8'h01);
    #1 check({7'h00, o_irq}, 8'h01);
    wr(PIRF_FLAGS_OFFSET, 8'h00);
    #1 check({7'h00, o_irq}, 8'h00);
    wr(PIRF_MASK_OFFSET, 8'h20);
    rx <= 1'b1;
    #1 check({7'h00, o_irq}, 8'h01);
    $display("test interrupt done");
    give_verdict();
  end
endmodule
